// ### codec_model.sv
`timescale 1ns/10ps
`default_nettype none

// Echoing codec: hands the device's own data back on the input line
module codec_model (
    input wire logic clk,
    input wire logic bclk,
    input wire logic fsync,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sdi,
    output int frame_bits,
    output int frames
);
    logic bclk_q;
    logic fs_q;
    logic last;
    int bits;

    initial begin
        bclk_q = 1'b0;
        fs_q = 1'b0;
        last = 1'b0;
        bits = 0;
        frame_bits = 0;
        frames = 0;
    end

    // Released line keeps changing, so a stale bit can never pass
    always_comb sdi = sdo_oe ? sdo : ~last;

    always @(posedge clk) begin
        bclk_q <= bclk;
        fs_q <= fsync;
        last <= sdo_oe ? sdo : ~last;
        if (fsync && !fs_q) begin
            frame_bits <= bits;
            bits <= (bclk && !bclk_q) ? 1 : 0;
            frames <= frames + 1;
        end else if (bclk && !bclk_q) begin
            bits <= bits + 1;
        end
    end
endmodule

`default_nettype wire

// ### codec_serial_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none

module codec_serial_interface_tb;
    import codec_serial_pkg::*;
    localparam int LIMIT = 40000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    logic cdir = 1'b0;
    logic fdir = 1'b0;
    logic idle = 1'b0;
    logic edge_sel = 1'b0;
    frame_mode_t mode = MODE_MULTI;
    logic [CNT_W-1:0] ws = 4'hf;
    logic [CNT_W-1:0] fl = 4'h3;
    logic [DIV_W-1:0] div = 12'h001;
    logic [NSLOT-1:0] slots = 16'hffff;
    logic tx_wr_valid = 1'b0;
    logic [PTR_W-1:0] tx_idx = 2'h0;
    logic [DATA_W-1:0] tx_data = 16'h0000;
    logic rx_ready = 1'b0;
    logic tx_wr_ready, rx_valid, rx_overflow;
    logic [DATA_W-1:0] rx_data;
    logic bclk_o, bclk_oe, fs_o, fs_oe, sdo_o, sdo_oe, sdi;
    int frame_bits, frames;
    logic [DATA_W-1:0] tx_mem [4];
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // Pins assumed pulled low when nobody drives them
    wire bclk_pin = bclk_oe ? bclk_o : 1'b0;
    wire fs_pin = fs_oe ? fs_o : 1'b0;

    codec_serial_port dut (.clk(clk), .rst_n(rst_n), .module_enable_bit(en),
        .bit_clock_direction(cdir), .frame_sync_direction(fdir), .idle_output_mode(idle),
        .sample_edge_select(edge_sel), .frame_mode(mode), .word_size_field(ws),
        .frame_length_field(fl), .bit_clock_divider(div), .slot_enable(slots),
        .tx_wr_valid(tx_wr_valid), .tx_wr_index(tx_idx), .tx_wr_data(tx_data),
        .tx_wr_ready(tx_wr_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overflow(rx_overflow), .serial_bit_clock_pin_i(bclk_pin),
        .serial_bit_clock_pin_o(bclk_o), .serial_bit_clock_pin_oe(bclk_oe),
        .frame_sync_pin_i(fs_pin), .frame_sync_pin_o(fs_o), .frame_sync_pin_oe(fs_oe),
        .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe), .serial_in_pin(sdi));

    codec_model partner (.clk(clk), .bclk(bclk_pin), .fsync(fs_pin), .sdo(sdo_o),
        .sdo_oe(sdo_oe), .sdi(sdi), .frame_bits(frame_bits), .frames(frames));

    always #25 clk = ~clk;

    task automatic finish_test();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic toggles(output int t);
        logic prev;
        t = 0;
        prev = bclk_o;
        repeat (40) begin
            @(negedge clk);
            if (bclk_o !== prev)
                t++;
            prev = bclk_o;
        end
    endtask

    // Waits for ready high (at most 20 cycles), then raises the strobe for one cycle
    task automatic wr(input logic [1:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        while (tx_wr_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        tx_wr_valid = 1'b1;
        tx_idx = idx;
        tx_data = d;
        tx_mem[idx] = d;
        @(negedge clk);
        tx_wr_valid = 1'b0;
    endtask

    task automatic run(input frame_mode_t m, input logic [3:0] w, input logic [3:0] f,
            input logic [15:0] s, input logic e, input logic i, input int nw, input bit stall);
        logic [15:0] mask;
        int k, n, snap, fexp, nfl;
        en = 1'b0;
        rx_ready = 1'b0;
        mode = m;
        ws = w;
        fl = f;
        slots = s;
        edge_sel = e;
        idle = i;
        repeat (3) @(negedge clk);
        for (k = 0; k < 4; k++)
            wr(2'(k), 16'($urandom));
        if (m == MODE_AC16 || m == MODE_AC20) begin
            mask = 16'hffff;
            fexp = 256;
        end else begin
            mask = 16'(16'hffff << (15 - w));
            fexp = (m == MODE_MULTI) ? (w + 1) * (f + 1) : 0;
        end
        en = 1'b1;
        k = 0;
        n = 0;
        nfl = 0;
        if (stall) begin
            while (rx_overflow !== 1'b1 && n < 1000) begin
                @(negedge clk);
                n++;
            end
            check_val("overflow", 16'h0001, 16'(rx_overflow));
            check_val("head word", tx_mem[0] & mask, rx_data);
            en = 1'b0;
            repeat (4) @(negedge clk);
            check_val("overflow cleared", 16'h0000, 16'(rx_overflow));
            check_val("rx valid cleared", 16'h0000, 16'(rx_valid));
            return;
        end
        while (k < nw && n < 3000) begin
            @(negedge clk);
            n++;
            if (sdo_oe !== 1'b1)
                nfl++;
            rx_ready = 1'($urandom);
            if (rx_ready && rx_valid === 1'b1) begin
                check_val("rx word", tx_mem[k % 4] & mask, rx_data);
                k++;
            end
        end
        rx_ready = 1'b0;
        check_cnt("rx words", nw, k);
        check_cnt("data out floats", int'(i), int'(nfl > 0));
        check_val("sync drive", 16'h0001, 16'(fs_oe));
        snap = frames;
        n = 0;
        while (frames < snap + 2 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (fexp > 0)
            check_cnt("frame bits", fexp, frame_bits);
    endtask

    initial begin
        int t;
        void'($urandom(18));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check_val("tx ready", 16'h0001, 16'(tx_wr_ready));
        check_val("rx valid", 16'h0000, 16'(rx_valid));
        check_val("data out drive", 16'h0000, 16'(sdo_oe));
        toggles(t);
        check_cnt("clock toggles", 20, t);
        check_val("clock drive", 16'h0001, 16'(bclk_oe));
        div = 12'h000;
        // Output register still carries the last generator phase for one edge
        repeat (3) @(negedge clk);
        toggles(t);
        check_cnt("clock toggles off", 0, t);
        div = 12'h001;
        cdir = 1'b1;
        fdir = 1'b1;
        en = 1'b1;
        repeat (4) @(negedge clk);
        check_val("clock drive", 16'h0000, 16'(bclk_oe));
        check_val("sync drive", 16'h0000, 16'(fs_oe));
        en = 1'b0;
        cdir = 1'b0;
        fdir = 1'b0;
        run(MODE_MULTI, 4'hf, 4'h3, 16'hffff, 1'b0, 1'b0, 8, 1'b0);
        run(MODE_MULTI, 4'h7, 4'h3, 16'h000d, 1'b1, 1'b1, 8, 1'b0);
        run(MODE_I2S, 4'hb, 4'h1, 16'hffff, 1'b1, 1'b0, 6, 1'b0);
        run(MODE_MULTI, 4'(2 + $urandom % 13), 4'h2, 16'hffff, 1'b0, 1'b0, 6, 1'b0);
        run(MODE_AC16, 4'h3, 4'h0, 16'hffff, 1'b0, 1'b0, 6, 1'b0);
        run(MODE_AC20, 4'h5, 4'h2, 16'hffff, 1'b0, 1'b0, 4, 1'b0);
        run(MODE_MULTI, 4'hf, 4'h3, 16'hffff, 1'b0, 1'b0, 0, 1'b1);
        finish_test();
    end
endmodule

`default_nettype wire

// ### codec_serial_pkg.sv
package codec_serial_pkg;

    localparam int DATA_W = 16;
    localparam int PTR_W = 2;
    localparam int ADDR_W = 3;
    localparam int DIV_W = 12;
    localparam int CNT_W = 4;
    localparam int NSLOT = 16;
    localparam int NWORDS = 8;
    localparam int FIFO_DEPTH = 2;

    // Buffer address spaces: receive low half, transmit high half
    localparam logic RX_SPACE = 1'b0;
    localparam logic TX_SPACE = 1'b1;

    // Protocol fixes 16 slots of 16 bit clocks in the AC-Link frame
    localparam logic [CNT_W-1:0] AC_WORD_LAST = 4'hf;
    localparam logic [CNT_W-1:0] AC_FRAME_LAST = 4'hf;
    localparam logic [CNT_W-1:0] FULL_WORD_LAST = 4'hf;

    localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_OFF = 12'h000;
    localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
    localparam logic [1:0] FILL_RST = 2'h0;
    localparam logic [1:0] FILL_FULL = 2'h2;

    typedef enum logic [1:0] {
        MODE_MULTI,
        MODE_I2S,
        MODE_AC16,
        MODE_AC20
    } frame_mode_t;

endpackage

// ### codec_serial_port.sv
`timescale 1ns/10ps
`default_nettype none

module codec_serial_port
    import codec_serial_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic module_enable_bit,
    input wire logic bit_clock_direction,
    input wire logic frame_sync_direction,
    input wire logic idle_output_mode,
    input wire logic sample_edge_select,
    input wire frame_mode_t frame_mode,
    input wire logic [CNT_W-1:0] word_size_field,
    input wire logic [CNT_W-1:0] frame_length_field,
    input wire logic [DIV_W-1:0] bit_clock_divider,
    input wire logic [NSLOT-1:0] slot_enable,
    input wire logic tx_wr_valid,
    input wire logic [PTR_W-1:0] tx_wr_index,
    input wire logic [DATA_W-1:0] tx_wr_data,
    output logic tx_wr_ready,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overflow,
    input wire logic serial_bit_clock_pin_i,
    output logic serial_bit_clock_pin_o,
    output logic serial_bit_clock_pin_oe,
    input wire logic frame_sync_pin_i,
    output logic frame_sync_pin_o,
    output logic frame_sync_pin_oe,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    input wire logic serial_in_pin
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic sck_int;
        logic [2:0] sck_sy;
        logic [2:0] fs_sy;
        logic bck;
        logic fs_lvl;
        logic fs_prev;
        logic [CNT_W-1:0] bitc;
        logic [CNT_W-1:0] fc;
        logic run;
        logic [PTR_W-1:0] ptr;
        logic [PTR_W-1:0] last_ptr;
        logic last_en;
        logic started;
        logic [DATA_W-1:0] sh;
        logic in_bit;
        logic tx_active;
        logic sck_o;
        logic sck_oe;
        logic fs_o;
        logic fs_oe;
        logic sdo_o;
        logic sdo_oe;
        logic pend;
        logic [PTR_W-1:0] pend_idx;
        logic [DATA_W-1:0] pend_data;
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] fq;
        logic [1:0] fill;
        logic rx_valid;
        logic ovf;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic [1:0] rst_q;
    logic rst_s;
    logic en;
    logic ac;
    logic bck_lvl;
    logic rise;
    logic fall;
    logic sample_edge;
    logic drive_edge;
    logic word_start;
    logic slot_on;
    logic push;
    logic [DATA_W-1:0] push_word;
    logic [CNT_W-1:0] wl_last;
    logic [CNT_W-1:0] fl_last;

    shadow_if sh_if ();

    shadow_mem u_mem (
        .clk(clk),
        .rst_s(rst_s),
        .port(sh_if.store)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_s = rst_q[1];

    assign en = module_enable_bit;
    assign ac = (frame_mode == MODE_AC16) || (frame_mode == MODE_AC20);
    assign wl_last = ac ? AC_WORD_LAST : word_size_field;
    assign fl_last = ac ? AC_FRAME_LAST : frame_length_field;

    // Pin level only counts once the second and third stages agree
    assign bck_lvl = bit_clock_direction
        ? ((s_r.sck_sy[1] == s_r.sck_sy[2]) ? s_r.sck_sy[2] : s_r.bck)
        : s_r.sck_int;
    assign rise = bck_lvl && !s_r.bck;
    assign fall = !bck_lvl && s_r.bck;
    assign sample_edge = sample_edge_select ? rise : fall;
    assign drive_edge = sample_edge_select ? fall : rise;
    assign word_start = en && s_r.run && drive_edge && (s_r.bitc == CNT_RST);
    assign slot_on = slot_enable[s_r.fc];
    assign push = word_start && s_r.started && s_r.last_en;
    // Shift the word left so the unused low bits read as zero
    assign push_word = DATA_W'({s_r.sh[DATA_W-2:0], s_r.in_bit}
        << (FULL_WORD_LAST - wl_last));

    always_comb begin
        sh_if.we = push;
        sh_if.waddr = push ? {RX_SPACE, s_r.last_ptr} : {TX_SPACE, s_r.pend_idx};
        sh_if.wdata = push ? push_word : s_r.pend_data;
        sh_if.raddr = {TX_SPACE, s_r.ptr};
        if (!push && s_r.pend) begin
            sh_if.we = 1'b1;
        end
    end

    always_comb begin
        logic fs_edge;
        logic pop;
        fs_edge = 1'b0;
        pop = 1'b0;
        s_nxt = s_r;
        s_nxt.sck_sy = {s_r.sck_sy[1:0], serial_bit_clock_pin_i};
        s_nxt.fs_sy = {s_r.fs_sy[1:0], frame_sync_pin_i};
        s_nxt.bck = bck_lvl;
        if (s_r.fs_sy[1] == s_r.fs_sy[2]) begin
            s_nxt.fs_lvl = s_r.fs_sy[2];
        end

        // Generator may run without the module so the pin can clock a codec
        if (bit_clock_divider == DIV_OFF || bit_clock_direction) begin
            s_nxt.div = DIV_RST;
            s_nxt.sck_int = 1'b0;
        end else if (s_r.div >= bit_clock_divider) begin
            s_nxt.div = DIV_RST;
            s_nxt.sck_int = !s_r.sck_int;
        end else begin
            s_nxt.div = DIV_W'(s_r.div + 12'h001);
        end
        s_nxt.sck_o = s_r.sck_int;
        s_nxt.sck_oe = !bit_clock_direction
            && (en || bit_clock_divider != DIV_OFF);
        s_nxt.fs_oe = en && !frame_sync_direction;

        if (sample_edge) begin
            s_nxt.in_bit = serial_in_pin;
            s_nxt.fs_prev = s_r.fs_lvl;
            if (frame_sync_direction && !s_r.run) begin
                fs_edge = (frame_mode == MODE_I2S) ? (s_r.fs_lvl != s_r.fs_prev)
                    : s_r.fs_lvl;
                if (fs_edge) begin
                    s_nxt.run = 1'b1;
                    s_nxt.bitc = CNT_RST;
                    s_nxt.fc = CNT_RST;
                end
            end
        end
        if (!frame_sync_direction) begin
            s_nxt.run = 1'b1;
        end

        if (en && s_r.run && drive_edge) begin
            if (word_start) begin
                s_nxt.last_ptr = s_r.ptr;
                s_nxt.last_en = slot_on;
                s_nxt.started = 1'b1;
                s_nxt.tx_active = slot_on;
                if (slot_on) begin
                    s_nxt.sdo_o = sh_if.rdata[DATA_W-1];
                    s_nxt.sh = {sh_if.rdata[DATA_W-2:0], s_r.in_bit};
                    s_nxt.ptr = PTR_W'(s_r.ptr + 2'h1);
                end else begin
                    s_nxt.sdo_o = 1'b0;
                    s_nxt.sh = {s_r.sh[DATA_W-2:0], s_r.in_bit};
                end
            end else begin
                s_nxt.sdo_o = s_r.tx_active && s_r.sh[DATA_W-1];
                s_nxt.sh = {s_r.sh[DATA_W-2:0], s_r.in_bit};
            end
            unique case (frame_mode)
                MODE_MULTI: s_nxt.fs_o = (s_r.fc == CNT_RST) && (s_r.bitc == CNT_RST);
                MODE_I2S: s_nxt.fs_o = s_r.fc[0];
                MODE_AC16, MODE_AC20: s_nxt.fs_o = (s_r.fc == CNT_RST);
            endcase
            if (s_r.bitc >= wl_last) begin
                s_nxt.bitc = CNT_RST;
                if (s_r.fc >= fl_last) begin
                    s_nxt.fc = CNT_RST;
                    s_nxt.run = !frame_sync_direction;
                end else begin
                    s_nxt.fc = CNT_W'(s_r.fc + 4'h1);
                end
            end else begin
                s_nxt.bitc = CNT_W'(s_r.bitc + 4'h1);
            end
        end
        s_nxt.sdo_oe = en && (s_nxt.tx_active || !idle_output_mode);
        if (!s_nxt.tx_active) begin
            s_nxt.sdo_o = 1'b0;
        end

        if (!push && s_r.pend) begin
            s_nxt.pend = 1'b0;
        end
        if (tx_wr_valid && !s_r.pend) begin
            s_nxt.pend = 1'b1;
            s_nxt.pend_idx = tx_wr_index;
            s_nxt.pend_data = tx_wr_data;
        end

        pop = s_r.rx_valid && rx_ready;
        if (pop) begin
            s_nxt.fq[0] = s_r.fq[1];
            s_nxt.fill = 2'(s_r.fill - 2'h1);
        end
        if (push) begin
            if (s_nxt.fill == FILL_FULL) begin
                s_nxt.ovf = 1'b1;
            end else begin
                s_nxt.fq[s_nxt.fill[0]] = push_word;
                s_nxt.fill = 2'(s_nxt.fill + 2'h1);
            end
        end

        if (!en) begin
            s_nxt.bitc = CNT_RST;
            s_nxt.fc = CNT_RST;
            s_nxt.ptr = PTR_RST;
            s_nxt.last_ptr = PTR_RST;
            s_nxt.run = 1'b0;
            s_nxt.started = 1'b0;
            s_nxt.last_en = 1'b0;
            s_nxt.tx_active = 1'b0;
            s_nxt.sh = WORD_RST;
            s_nxt.fs_o = 1'b0;
            s_nxt.sdo_o = 1'b0;
            s_nxt.fill = FILL_RST;
            s_nxt.ovf = 1'b0;
        end
        s_nxt.rx_valid = s_nxt.fill != FILL_RST;
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_wr_ready = !s_r.pend;
    assign rx_data = s_r.fq[0];
    assign rx_valid = s_r.rx_valid;
    assign rx_overflow = s_r.ovf;
    assign serial_bit_clock_pin_o = s_r.sck_o;
    assign serial_bit_clock_pin_oe = s_r.sck_oe;
    assign frame_sync_pin_o = s_r.fs_o;
    assign frame_sync_pin_oe = s_r.fs_oe;
    assign serial_out_pin_o = s_r.sdo_o;
    assign serial_out_pin_oe = s_r.sdo_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s);

    a_clk_dir_ext: assert property (bit_clock_direction |=> !serial_bit_clock_pin_oe)
        else $error("bit clock pin driven while external");
    a_idle_zero: assert property (serial_out_pin_oe && !s_r.tx_active |-> !serial_out_pin_o)
        else $error("data out not zero in idle slot");
    a_sync_dir: assert property (frame_sync_direction |=> !frame_sync_pin_oe)
        else $error("sync pin driven in slave");
    a_rx_low_zero: assert property (push && wl_last == 4'h7 |-> push_word[7:0] == 8'h00)
        else $error("unused receive bits not zero");
    a_disable_clear: assert property (!en |=> s_r.ptr == PTR_RST && s_r.fc == CNT_RST)
        else $error("counters not reset on disable");
    a_clock_stopped: assert property (!en && bit_clock_divider == DIV_OFF
        |=> ##1 !serial_bit_clock_pin_o)
        else $error("bit clock toggling while stopped");
    a_gen_alone: assert property (!bit_clock_direction && bit_clock_divider != DIV_OFF
        |=> serial_bit_clock_pin_oe)
        else $error("generator not driving clock pin");
    a_frame_cap: assert property (s_r.fc <= fl_last || $changed(fl_last))
        else $error("frame counter beyond frame length");
    a_ptr_step: assert property (word_start && slot_on
        |=> s_r.ptr == $past(s_r.ptr) + 2'h1)
        else $error("pointer did not advance");
    a_ac_fixed: assert property (ac && en && s_r.run && drive_edge && s_r.bitc == 4'hf
        && s_r.fc == 4'hf |=> s_r.fc == CNT_RST)
        else $error("AC-Link frame not 256 bit clocks");

    c_frame_wrap: cover property (word_start && s_r.fc == CNT_RST && s_r.started);
    c_rx_push: cover property (push && s_r.rx_valid);
    c_slave_start: cover property (frame_sync_direction && !s_r.run ##1 s_r.run);
    c_overflow: cover property ($rose(s_r.ovf));

endmodule

`default_nettype wire

// ### shadow_if.sv
`timescale 1ns/10ps
`default_nettype none

interface shadow_if;
    import codec_serial_pkg::*;
    logic we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;

    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ### shadow_mem.sv
`timescale 1ns/10ps
`default_nettype none

module shadow_mem
    import codec_serial_pkg::*;
(
    input wire logic clk,
    input wire logic rst_s,
    shadow_if.store port
);

    typedef struct packed {
        logic [NWORDS-1:0][DATA_W-1:0] mem;
        logic [DATA_W-1:0] rdata;
    } mem_state_t;

    mem_state_t m_r;
    mem_state_t m_nxt;

    always_comb begin
        m_nxt = m_r;
        if (port.we) begin
            m_nxt.mem[port.waddr] = port.wdata;
        end
        // Read data is registered; callers see it one cycle after the address
        m_nxt.rdata = m_r.mem[port.raddr];
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            m_r <= '0;
        end else begin
            m_r <= m_nxt;
        end
    end

    assign port.rdata = m_r.rdata;

endmodule

`default_nettype wire
